//--- rtl/internal_clock_source_select.v
`timescale 1ns/1ps
`default_nettype none
`include "clock_select_defines.vh"

module internal_clock_source_select (
    input wire pclk,
    input wire presetn,
    input wire psel,
    input wire penable,
    input wire pwrite,
    input wire [7:0] paddr,
    input wire [31:0] pwdata,
    output reg [31:0] prdata_r,
    output reg pready_r,
    output reg pslverr_r,
    input wire [2:0] reset_clock_select,
    input wire clock_out_pin_enable,
    output reg sys_clk_tick_r,
    output reg clock_out_pin_data_r,
    output reg clock_out_pin_oe_r
);
    localparam [63:0] PHASE_ONE = 64'd1 << `PHASE_BITS;
    localparam [63:0] INC_SLOW_W = (`SLOW_OSC_HZ * PHASE_ONE) / `PCLK_HZ;
    localparam [23:0] INC_SLOW = INC_SLOW_W[23:0];

    // configuration words, caught once after reset release
    reg cfg_loaded_r;
    reg [2:0] cfg_src_r;
    reg cfg_clkout_r;

    reg [2:0] new_clock_select_r;
    reg [3:0] clock_divider_select_r;
    reg [2:0] fast_osc_freq_select_r;

    reg [23:0] fast_phase_r;
    reg [23:0] slow_phase_r;
    reg fast_tick_r;
    reg slow_tick_r;
    reg [1:0] clkout_cnt_r;

    reg [63:0] fast_hz;
    reg [63:0] fast_inc_w;
    reg [23:0] fast_inc;
    reg pll_ok;
    reg src_tick;
    reg [31:0] rd_data;
    reg rd_err;

    wire [24:0] fast_sum;
    wire [24:0] slow_sum;
    wire div_tick;
    wire access;
    wire pll_req;

    assign pll_req = (new_clock_select_r == `SRC_FAST_PLL);
    assign access = psel & penable & pready_r;

    // oscillator rate from the frequency code
    always @* begin
        case (fast_osc_freq_select_r)
            `FRQ_1MHZ: fast_hz = 64'd1 * `MHZ;
            `FRQ_2MHZ: fast_hz = 64'd2 * `MHZ;
            `FRQ_4MHZ: fast_hz = 64'd4 * `MHZ;
            `FRQ_8MHZ: fast_hz = 64'd8 * `MHZ;
            `FRQ_12MHZ: fast_hz = 64'd12 * `MHZ;
            `FRQ_16MHZ: fast_hz = 64'd16 * `MHZ;
            default: fast_hz = 64'd32 * `MHZ;
        endcase
    end

    // the doubler only locks on the three legal input rates
    always @* begin
        pll_ok = pll_req &&
            (fast_osc_freq_select_r == `FRQ_8MHZ ||
             fast_osc_freq_select_r == `FRQ_12MHZ ||
             fast_osc_freq_select_r == `FRQ_16MHZ);
    end

    // increments stay below 2^24 for every legal rate, so the cut loses nothing
    always @* begin
        if (pll_ok) begin
            fast_inc_w = ((fast_hz << 1) * PHASE_ONE) / `PCLK_HZ;
        end else begin
            fast_inc_w = (fast_hz * PHASE_ONE) / `PCLK_HZ;
        end
        fast_inc = fast_inc_w[23:0];
    end

    assign fast_sum = {1'b0, fast_phase_r} + {1'b0, fast_inc};
    assign slow_sum = {1'b0, slow_phase_r} + {1'b0, INC_SLOW};

    // two free running oscillators modelled as phase accumulators
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            fast_phase_r <= 24'h000000;
            slow_phase_r <= 24'h000000;
            fast_tick_r <= 1'b0;
            slow_tick_r <= 1'b0;
        end else begin
            fast_phase_r <= fast_sum[23:0];
            fast_tick_r <= fast_sum[24];
            slow_phase_r <= slow_sum[23:0];
            slow_tick_r <= slow_sum[24];
        end
    end

    // source mux; no source tick reaches the divider until the configuration words are in
    always @* begin
        if (!cfg_loaded_r) begin
            src_tick = 1'b0;
        end else if (new_clock_select_r == `SRC_SLOW) begin
            src_tick = slow_tick_r;
        end else begin
            src_tick = fast_tick_r;
        end
    end

    clock_ratio_divider u_div (
        .pclk(pclk),
        .presetn(presetn),
        .src_tick(src_tick),
        .ratio_sel(clock_divider_select_r),
        .div_tick_r(div_tick)
    );

    // read mux
    always @* begin
        rd_data = 32'h00000000;
        rd_err = 1'b0;
        if (paddr == `OFS_CLOCK_SWITCH_CONTROL) begin
            rd_data[`CSC_NEW_MSB:`CSC_NEW_LSB] = new_clock_select_r;
            rd_data[`CSC_DIV_MSB:`CSC_DIV_LSB] = clock_divider_select_r;
        end else if (paddr == `OFS_FAST_OSC_FREQUENCY) begin
            rd_data[`FRQ_MSB:`FRQ_LSB] = fast_osc_freq_select_r;
        end else if (paddr == `OFS_CLOCK_STATUS) begin
            rd_data[2:0] = new_clock_select_r;
            rd_data[3] = pll_ok;
            rd_data[4] = cfg_loaded_r;
        end else if (paddr == `OFS_CONFIG_VIEW) begin
            rd_data[2:0] = cfg_src_r;
            rd_data[3] = cfg_clkout_r;
        end else begin
            rd_err = 1'b1;
        end
    end

    // apb: one wait state, pready rises in the second access cycle
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pready_r <= 1'b0;
            prdata_r <= 32'h00000000;
            pslverr_r <= 1'b0;
        end else begin
            pready_r <= psel & penable & ~pready_r;
            if (psel & penable & ~pready_r) begin
                prdata_r <= pwrite ? 32'h00000000 : rd_data;
                pslverr_r <= rd_err |
                    (pwrite & (paddr == `OFS_CLOCK_STATUS || paddr == `OFS_CONFIG_VIEW));
            end else begin
                prdata_r <= 32'h00000000;
                pslverr_r <= 1'b0;
            end
        end
    end

    // configuration capture and software control registers
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            cfg_loaded_r <= 1'b0;
            cfg_src_r <= `SRC_FAST;
            cfg_clkout_r <= 1'b0;
            new_clock_select_r <= `SRC_FAST;
            clock_divider_select_r <= `RST_DIV_SEL;
            fast_osc_freq_select_r <= `FRQ_1MHZ;
        end else if (!cfg_loaded_r) begin
            cfg_loaded_r <= 1'b1;
            cfg_src_r <= reset_clock_select;
            cfg_clkout_r <= clock_out_pin_enable;
            clock_divider_select_r <= `RST_DIV_SEL;
            if (reset_clock_select == `SRC_FAST_PLL) begin
                new_clock_select_r <= `SRC_FAST_PLL;
                fast_osc_freq_select_r <= `FRQ_16MHZ;
            end else if (reset_clock_select == `SRC_SLOW) begin
                new_clock_select_r <= `SRC_SLOW;
                fast_osc_freq_select_r <= `FRQ_1MHZ;
            end else begin
                new_clock_select_r <= `SRC_FAST;
                fast_osc_freq_select_r <= `FRQ_1MHZ;
            end
        end else if (access & pwrite) begin
            if (paddr == `OFS_CLOCK_SWITCH_CONTROL) begin
                // unknown source codes are dropped so the clock never stops
                if (pwdata[`CSC_NEW_MSB:`CSC_NEW_LSB] == `SRC_FAST_PLL ||
                    pwdata[`CSC_NEW_MSB:`CSC_NEW_LSB] == `SRC_FAST ||
                    pwdata[`CSC_NEW_MSB:`CSC_NEW_LSB] == `SRC_SLOW) begin
                    new_clock_select_r <= pwdata[`CSC_NEW_MSB:`CSC_NEW_LSB];
                end
                if (pwdata[`CSC_DIV_MSB:`CSC_DIV_LSB] > `DIV_SEL_MAX) begin
                    clock_divider_select_r <= `DIV_SEL_MAX;
                end else begin
                    clock_divider_select_r <= pwdata[`CSC_DIV_MSB:`CSC_DIV_LSB];
                end
            end else if (paddr == `OFS_FAST_OSC_FREQUENCY) begin
                fast_osc_freq_select_r <= pwdata[`FRQ_MSB:`FRQ_LSB];
            end
        end
    end

    // system clock tick and clock-out pin (system clock divided by four)
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            sys_clk_tick_r <= 1'b0;
            clkout_cnt_r <= 2'h0;
            clock_out_pin_data_r <= 1'b0;
            clock_out_pin_oe_r <= 1'b0;
        end else begin
            sys_clk_tick_r <= div_tick;
            if (div_tick) begin
                clkout_cnt_r <= clkout_cnt_r + 2'h1;
            end
            clock_out_pin_data_r <= cfg_clkout_r & clkout_cnt_r[1];
            clock_out_pin_oe_r <= cfg_clkout_r;
        end
    end
endmodule // internal_clock_source_select

`default_nettype wire

//--- rtl/clock_select_defines.vh
`ifndef CLOCK_SELECT_DEFINES_VH
`define CLOCK_SELECT_DEFINES_VH

// register byte offsets
`define OFS_CLOCK_SWITCH_CONTROL 8'h00
`define OFS_FAST_OSC_FREQUENCY 8'h04
`define OFS_CLOCK_STATUS 8'h08
`define OFS_CONFIG_VIEW 8'h0c

// clock_switch_control_reg fields
`define CSC_DIV_LSB 0
`define CSC_DIV_MSB 3
`define CSC_NEW_LSB 4
`define CSC_NEW_MSB 6

// fast_osc_frequency_reg field
`define FRQ_LSB 0
`define FRQ_MSB 2

// source codes, shared by reset_clock_select and new_clock_select
`define SRC_FAST_PLL 3'h0
`define SRC_SLOW 3'h5
`define SRC_FAST 3'h6

// fast_osc_freq_select codes
`define FRQ_1MHZ 3'h0
`define FRQ_2MHZ 3'h1
`define FRQ_4MHZ 3'h2
`define FRQ_8MHZ 3'h3
`define FRQ_12MHZ 3'h4
`define FRQ_16MHZ 3'h6
`define FRQ_32MHZ 3'h7

// reset value and largest divider select
`define RST_DIV_SEL 4'h0
`define DIV_SEL_MAX 4'h9

// timing: pclk rate and oscillator rates in hertz
`define PCLK_HZ 64'd200000000
`define SLOW_OSC_HZ 64'd31000
`define MHZ 64'd1000000
`define PHASE_BITS 24

`endif

//--- rtl/clock_ratio_divider.v
`timescale 1ns/1ps
`default_nettype none

module clock_ratio_divider (
    input wire pclk,
    input wire presetn,
    input wire src_tick,
    input wire [3:0] ratio_sel,
    output reg div_tick_r
);
    reg [8:0] count_r;
    wire [8:0] mask;

    // bit i of the mask is set when ratio_sel is above i
    genvar i;
    generate
        for (i = 0; i < 9; i = i + 1) begin : g_mask
            assign mask[i] = (ratio_sel > i);
        end
    endgenerate

    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            count_r <= 9'h000;
            div_tick_r <= 1'b0;
        end else begin
            div_tick_r <= 1'b0;
            if (src_tick) begin
                if ((count_r & mask) == mask) begin
                    count_r <= 9'h000;
                    div_tick_r <= 1'b1;
                end else begin
                    count_r <= count_r + 9'h001;
                end
            end
        end
    end
endmodule // clock_ratio_divider

`default_nettype wire

//--- tb/clock_select_properties.sv
`timescale 1ns/1ps
`default_nettype none
module clock_select_properties (
    input wire pclk,
    input wire presetn,
    input wire psel,
    input wire penable,
    input wire pwrite,
    input wire [7:0] paddr,
    input wire [31:0] prdata_r,
    input wire pready_r,
    input wire pslverr_r,
    input wire clock_out_pin_enable,
    input wire sys_clk_tick_r,
    input wire clock_out_pin_data_r,
    input wire clock_out_pin_oe_r
);
    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);
    sequence setup_s; psel && !penable; endsequence
    sequence access_s; psel && penable; endsequence
    one_wait_state_a: assert property (setup_s ##1 access_s |-> !pready_r ##1 pready_r)
        else $error("ready not in second access cycle");
    ready_pulse_a: assert property (pready_r |=> !pready_r) else $error("ready held");
    ready_in_access_a: assert property (pready_r |-> psel && penable) else $error("stray ready");
    error_with_ready_a: assert property (pslverr_r |-> pready_r) else $error("stray error");
    rdata_idle_zero_a: assert property (!pready_r |-> prdata_r == 32'h0) else $error("rdata");
    ro_write_refused_a: assert property (pready_r && pwrite && paddr[3] |-> pslverr_r)
        else $error("read-only write accepted");
    unmapped_refused_a: assert property (pready_r && paddr > 8'h0c |-> pslverr_r)
        else $error("unmapped accepted");
    pin_idle_low_a: assert property (!clock_out_pin_oe_r |-> !clock_out_pin_data_r)
        else $error("pin data while not driven");
    pin_enable_cause_a: assert property ($rose(clock_out_pin_oe_r) |-> clock_out_pin_enable)
        else $error("pin driven without enable");
    tick_pulse_a: assert property (sys_clk_tick_r |=> !sys_clk_tick_r)
        else $error("tick too long");
endmodule // clock_select_properties
bind internal_clock_source_select clock_select_properties u_props (.pclk(pclk),
    .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
    .prdata_r(prdata_r), .pready_r(pready_r), .pslverr_r(pslverr_r),
    .clock_out_pin_enable(clock_out_pin_enable), .sys_clk_tick_r(sys_clk_tick_r),
    .clock_out_pin_data_r(clock_out_pin_data_r), .clock_out_pin_oe_r(clock_out_pin_oe_r));
`default_nettype wire

//--- tb/testbench.sv
`timescale 1ns/1ps
`default_nettype none
module testbench;
    logic pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0, coe = 0;
    logic [7:0] paddr = 8'h00;
    logic [31:0] pwdata = 32'h0, prdata_r, q;
    logic pready_r, pslverr_r, tick, pin_d, pin_oe, e;
    logic [2:0] rcs = 3'h0;
    integer n_mismatch = 0, checked = 0, nt, nc;
    always #2.5 pclk = ~pclk;
    internal_clock_source_select uut (.pclk(pclk), .presetn(presetn), .psel(psel),
        .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
        .prdata_r(prdata_r), .pready_r(pready_r), .pslverr_r(pslverr_r),
        .reset_clock_select(rcs), .clock_out_pin_enable(coe), .sys_clk_tick_r(tick),
        .clock_out_pin_data_r(pin_d), .clock_out_pin_oe_r(pin_oe));
    task chk(input logic [31:0] s, input logic [31:0] x);
        checked++;
        if (s !== x) begin
            n_mismatch++;
            $display("MISMATCH %0t seen %h expected %h", $time, s, x);
        end
    endtask
    task apb(input logic w, input logic [7:0] a, input logic [31:0] d);
        @(posedge pclk);
        psel <= 1; penable <= 0; pwrite <= w; paddr <= a; pwdata <= d;
        @(posedge pclk);
        penable <= 1;
        // only the watchdog ends a hung transfer
        do begin @(posedge pclk); end while (pready_r !== 1'b1);
        q = prdata_r;
        e = pslverr_r;
        psel <= 0;
        penable <= 0;
    endtask
    task rd(input logic [7:0] a, input logic [31:0] x, input logic xe);
        apb(0, a, 32'h0);
        chk(q, x);
        chk(e, xe);
    endtask
    // counts system ticks and clock-out rising edges over n cycles
    task cnt(input integer n, input integer lo, input integer hi);
        logic p;
        nt = 0; nc = 0; p = pin_d;
        repeat (n) begin
            @(posedge pclk);
            if (tick === 1'b1) nt++;
            if (pin_d === 1'b1 && p === 1'b0) nc++;
            p = pin_d;
        end
        chk(nt >= lo && nt <= hi, 1);
    endtask
    task rst(input logic [2:0] c, input logic o);
        presetn <= 0; rcs <= c; coe <= o;
        repeat (4) @(posedge pclk);
        presetn <= 1;
        repeat (2) @(posedge pclk);
    endtask
    task s_reset_doubled;
        rst(3'h0, 1);
        rd(8'h0c, 32'h8, 0);
        rd(8'h04, 32'h6, 0);
        rd(8'h08, 32'h18, 0);
        cnt(1000, 158, 162);
        chk(nc >= 38 && nc <= 42, 1);
        chk(pin_oe, 1);
    endtask
    task s_reset_fast;
        rst(3'h6, 0);
        rd(8'h04, 32'h0, 0);
        rd(8'h08, 32'h16, 0);
        cnt(1000, 4, 6);
        chk({pin_oe, nc[7:0]}, 0);
    endtask
    task s_switch;
        apb(1, 8'h04, 32'h7);
        cnt(1000, 158, 162);
        apb(1, 8'h00, 32'h03);
        rd(8'h08, 32'h10, 0);
        apb(1, 8'h04, 32'h3);
        rd(8'h08, 32'h18, 0);
        cnt(1000, 9, 11);
        apb(1, 8'h00, 32'h50);
        rd(8'h08, 32'h15, 0);
        cnt(13000, 1, 3);
        apb(1, 8'h00, 32'h7f);
        rd(8'h00, 32'h59, 0);
        apb(1, 8'h04, 32'h7);
        apb(1, 8'h00, 32'h69);
        cnt(6400, 1, 3);
    endtask
    task s_refuse;
        apb(1, 8'h08, 32'h0);
        chk(e, 1);
        rd(8'h08, 32'h16, 0);
        rd(8'h10, 32'h0, 1);
    endtask
    task s_reset_other;
        rst(3'h5, 1);
        rd(8'h0c, 32'hd, 0);
        rd(8'h08, 32'h15, 0);
        chk(pin_oe, 1);
        rst(3'h3, 0);
        rd(8'h08, 32'h16, 0);
        rd(8'h04, 32'h0, 0);
        chk(pin_oe, 0);
    endtask
    task test_done;
        if (n_mismatch == 0 && checked > 0) $display("verification passed");
        else $display("verification failed");
        $finish;
    endtask
    initial begin
        s_reset_doubled;
        s_reset_fast;
        s_switch;
        s_refuse;
        s_reset_other;
        test_done;
    end
    initial begin
        #400000;
        n_mismatch++;
        test_done;
    end
endmodule // testbench
`default_nettype wire
